// >>> sim/gwa_gateway_bench.sv
// gwa_gateway_bench: self-checking bench of the gateway address and status block
`timescale 1ns/1ps
module gwa_gateway_bench;
    import gwa_pkg::*;
    localparam int TK = 8;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, rom = 1'b0, tx = 1'b0, rxv = 1'b0;
    logic        talk = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [7:0]  sw = 8'h00, node = 8'h00;
    logic [31:0] wd = 32'h0, q, rdat, seed = 32'h97327068;
    logic [15:0] ubd, fbd;
    logic [4:0]  pa;
    logic [2:0]  en;
    logic [1:0]  slot, fslot;
    logic        wt, irq, trf, pv, hit, amode, acc, ls, la, lu, lf, lb;
    int          err_total = 0, checked = 0, c, b;
    ////////////////////////////////////////
    always #5 clk_i = ~clk_i;
    gwa_gateway #(.TICK_CYCLES(TK)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq),
        .sw_i(sw), .rom_fault_i(rom), .up_traffic_i(trf), .up_poll_valid_i(pv), .up_poll_addr_i(pa),
        .up_hit_o(hit), .up_slot_o(slot), .analog_mode_o(amode), .up_baud_div_o(ubd),
        .fb_tx_i(tx), .fb_rx_valid_i(rxv), .fb_rx_node_i(node), .fb_rx_accept_o(acc),
        .fb_rx_slot_o(fslot), .fb_baud_div_o(fbd), .led_status_o(ls), .led_alarm_o(la),
        .led_up_o(lu), .led_fb_o(lf), .led_fb_bright_o(lb)
    );
    gwa_site_ctrl site (.clk_i(clk_i), .talk_i(talk), .traffic_o(trf), .poll_valid_o(pv), .poll_addr_o(pa));
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] udiv(input logic [1:0] s);
        int r[4] = '{UP_BAUD_0, UP_BAUD_1, UP_BAUD_2, UP_BAUD_3};
        return 16'(CLK_HZ / r[s]);
    endfunction
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // waitrequest sampled at the rising edge; one idle edge keeps two requests apart
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
        end while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        adr <= ~a;
        @(posedge clk_i);
    endtask
    task automatic alarm(input gwa_alarm_t e);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("alarm code", q[ST_ALARM_LSB+:3], e);
    endtask
    // window is whole ticks, so a periodic led gives an exact count
    task automatic rises(input int w, input int t);
        logic p, v;
        @(negedge clk_i);
        p = (w == 0) ? ls : (w == 1) ? la : lu;
        c = 0;
        repeat (t * TK) begin
            @(negedge clk_i);
            v = (w == 0) ? ls : (w == 1) ? la : lu;
            if (v === 1'b1 && p === 1'b0)
                c++;
            p = v;
        end
        @(posedge clk_i);
    endtask
    task automatic rx(input logic [7:0] n);
        rxv <= 1'b1;
        node <= n;
        @(posedge clk_i);
        rxv <= 1'b0;
        node <= ~n;
        @(negedge clk_i);
        chk("rx accept", acc, n >= 1 && n <= 3);
        if (acc === 1'b1)
            chk("rx slot", fslot, n - 8'h01);
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge clk_i);
        err_total++;
        results;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("fb div reset", fbd, FB_DIV_RST);
        alarm(ALM_UNCFG);
        rises(1, 8);
        chk("unconfigured flash", c, 2);
        rises(0, 16);
        chk("status flash", c, 2);
        rom <= 1'b1;
        repeat (3) @(posedge clk_i);
        alarm(ALM_HW);
        rises(1, 8);
        chk("hw flash", c, 4);
        rom <= 1'b0;
        bus(1'b1, REG_IRQ_MASK, 32'h0);
        bus(1'b1, REG_CTRL, 32'hf);
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", q, 32'hf);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", q, 32'h0);
        seed = xs(seed);
        bus(1'b1, REG_FB_BAUD, {16'h0, seed[15:0]});
        @(negedge clk_i);
        chk("fb div", fbd, seed[15:0]);
        @(posedge clk_i);
        talk <= 1'b1;
        alarm(ALM_OFFLINE);
        rises(1, 8);
        chk("offline steady", {c[7:0], la}, 9'h001);
        rises(2, 8);
        chk("up flash", c > 0, 1'b1);
        rx(8'h00);
        rx(8'h04);
        rx(8'hff);
        chk("refused no led", lb, 1'b0);
        rx(8'h01);
        @(negedge clk_i);
        chk("bright", {lb, lf, irq}, 3'b110);
        @(posedge clk_i);
        rx(8'h03);
        bus(1'b1, REG_IRQ_MASK, 32'h1 << IRQ_FB_RX);
        @(negedge clk_i);
        chk("irq raised", irq, 1'b1);
        @(posedge clk_i);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq stat", q[IRQ_W-1:0], (1 << IRQ_FB_RX) | (1 << IRQ_HW));
        @(negedge clk_i);
        chk("irq cleared", irq, 1'b0);
        @(posedge clk_i);
        rx(8'h02);
        repeat (3 * TK - 4) @(posedge clk_i);
        @(negedge clk_i);
        chk("bright held", lb, 1'b1);
        repeat (TK + 8) @(posedge clk_i);
        @(negedge clk_i);
        chk("bright ends", lb, 1'b0);
        @(posedge clk_i);
        alarm(ALM_NONE);
        chk("online", {q[ST_ONLINE_LSB+:3], la}, 4'he);
        tx <= 1'b1;
        @(posedge clk_i);
        tx <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("tx blink", lf, 1'b1);
        repeat (2 * TK) @(posedge clk_i);
        chk("tx blink ends", lf, 1'b0);
        talk <= 1'b0;
        repeat (100 * TK) @(posedge clk_i);
        alarm(ALM_UP_LOST);
        rises(1, 8);
        chk("loss flash", c, 1);
        rises(2, 8);
        chk("quiet up led", c, 0);
        talk <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            b = (i == 0) ? 0 : (i == 7) ? 14 : seed[7:0] % 15;
            en = seed[15:13];
            sw <= {i[2], 2'(i), seed[9], 4'(b)};
            bus(1'b1, REG_CTRL, {28'h0, 1'b1, en});
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk("mode", amode, i[2]);
            chk("up div", ubd, udiv(2'(i)));
            @(posedge clk_i);
            bus(1'b0, REG_STATUS, 32'h0);
            chk("switches", {q[ST_SW5_ON], q[7:0]}, {seed[9], 1'b0, 2'(i), i[2], 4'(b)});
            for (int a = -1; a <= 4; a++) begin
                site.poll(5'(b + a));
                @(negedge clk_i);
                chk("poll hit", hit, (a >= 0 && a <= 2) ? en[a] : 1'b0);
                if (hit === 1'b1)
                    chk("poll slot", slot, a);
                @(posedge clk_i);
            end
        end
        results;
    end
endmodule // gwa_gateway_bench

// >>> sim/gwa_site_ctrl.sv
// gwa_site_ctrl: behavioural site controller on the upstream network
`timescale 1ns/1ps
module gwa_site_ctrl (
    // clock and enable
    input  wire logic  clk_i,
    input  wire logic  talk_i,
    // upstream activity
    output logic       traffic_o,
    output logic       poll_valid_o,
    output logic [4:0] poll_addr_o
);
    ////////////////////////////////////////
    int gap = 0;
    initial begin
        traffic_o = 1'b0;
        poll_valid_o = 1'b0;
        poll_addr_o = 5'h00;
    end
    // chatter only while talking; silence lets the loss timer run
    always @(posedge clk_i) begin
        gap <= gap + 1;
        traffic_o <= talk_i && (gap % 7 == 0);
    end
    // same baud setting as every party on the net assumed
    task automatic poll(input logic [4:0] a);
        poll_valid_o <= 1'b1;
        poll_addr_o <= a;
        @(posedge clk_i);
        poll_valid_o <= 1'b0;
        poll_addr_o <= ~a; // released lines show junk, not the old value
    endtask
endmodule // gwa_site_ctrl

// >>> verilog/gwa_gateway.sv
// gwa_gateway: board-address emulation, status LEDs and register slave of the gateway
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module gwa_gateway
    import gwa_pkg::*;
#(
    parameter int TICK_CYCLES = gwa_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             irq_o,
    // configuration switches and hardware check
    input  wire logic [7:0]  sw_i,
    input  wire logic        rom_fault_i,
    // upstream protocol side
    input  wire logic        up_traffic_i,
    input  wire logic        up_poll_valid_i,
    input  wire logic [4:0]  up_poll_addr_i,
    output logic             up_hit_o,
    output logic [1:0]       up_slot_o,
    output logic             analog_mode_o,
    output logic [15:0]      up_baud_div_o,
    // field-bus side
    input  wire logic        fb_tx_i,
    input  wire logic        fb_rx_valid_i,
    input  wire logic [7:0]  fb_rx_node_i,
    output logic             fb_rx_accept_o,
    output logic [1:0]       fb_rx_slot_o,
    output logic [15:0]      fb_baud_div_o,
    // indicators
    output logic             led_status_o,
    output logic             led_alarm_o,
    output logic             led_up_o,
    output logic             led_fb_o,
    output logic             led_fb_bright_o
);
    import gwa_pkg::*;

    typedef struct packed {
        logic [7:0]             sw1;
        logic [7:0]             sw2;
        logic [23:0]            tick_cnt;
        logic                   tick;
        logic [2:0]             phase;
        logic [SLOTS-1:0]       slot_en;
        logic                   cfg;
        logic [15:0]            fb_div;
        logic [IRQ_W-1:0]       irq_stat;
        logic [IRQ_W-1:0]       irq_mask;
        logic                   ack;
        logic [31:0]            rdata;
        logic [7:0]             up_cnt;
        logic                   up_lost;
        logic [SLOTS-1:0][7:0]  mon_cnt;
        logic [SLOTS-1:0]       online;
        logic                   hw_prev;
        logic                   hit;
        logic [1:0]             slot;
        logic                   acc;
        logic [1:0]             acc_slot;
        logic                   mode;
        logic [15:0]            up_div;
        gwa_alarm_t             alarm;
        logic                   led_stat;
        logic                   led_alarm;
        logic                   led_up;
        logic                   led_fb;
        logic                   led_br;
    } gwa_state_t;

    localparam gwa_state_t ST_RST = '{fb_div: FB_DIV_RST, alarm: ALM_NONE, default: '0};

    gwa_state_t       q;
    gwa_state_t       d;
    logic             map_hit;
    logic [1:0]       map_slot;
    logic             node_ok;
    logic             req;
    logic             up_str;
    logic             tx_str;
    logic             br_str;
    logic [IRQ_W-1:0] irq_set;
    logic [3:0]       base;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    gwa_slot_map #(.SLOTS(SLOTS)) u_map (
        .base_i    (base),
        .slot_en_i (q.slot_en),
        .addr_i    (up_poll_addr_i),
        .hit_o     (map_hit),
        .slot_o    (map_slot)
    );

    gwa_stretch #(.LEN(FLASH_TICKS)) u_up_flash (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_i   (q.tick),
        .trig_i   (up_traffic_i),
        .active_o (up_str)
    );

    gwa_stretch #(.LEN(FLASH_TICKS)) u_fb_flash (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_i   (q.tick),
        .trig_i   (fb_tx_i),
        .active_o (tx_str)
    );

    gwa_stretch #(.LEN(BRIGHT_TICKS)) u_fb_bright (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .tick_i   (q.tick),
        .trig_i   (node_ok),
        .active_o (br_str)
    );

    function automatic logic [31:0] status_word(input gwa_state_t s);
        status_word = '0;
        status_word[ST_BASE_LSB +: SW_BASE_W] = s.sw2[SW_BASE_LSB +: SW_BASE_W];
        status_word[ST_MODE] = s.mode;
        status_word[ST_BAUD_LSB +: SW_BAUD_W] = s.sw2[SW_BAUD_LSB +: SW_BAUD_W];
        status_word[ST_BASE_BAD] = (s.sw2[SW_BASE_LSB +: SW_BASE_W] > 4'(MAX_BASE));
        status_word[ST_ONLINE_LSB +: SLOTS] = s.online;
        status_word[ST_UP_LOST] = s.up_lost;
        status_word[ST_HW] = s.hw_prev;
        status_word[ST_SW5_ON] = s.sw2[SW_FB_RSVD];
        status_word[ST_ALARM_LSB +: 3] = s.alarm;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    assign base    = q.sw2[SW_BASE_LSB +: SW_BASE_W];
    assign req     = avs_read_i | avs_write_i;
    assign node_ok = fb_rx_valid_i && fb_rx_node_i >= 8'h01 && fb_rx_node_i <= 8'(SLOTS);

    always_comb begin
        d = q;
        // switches are pins: two flops before use
        d.sw1  = sw_i;
        d.sw2  = q.sw1;
        d.tick = 1'b0;
        if (q.tick_cnt == 24'(TICK_CYCLES - 1)) begin
            d.tick_cnt = '0;
            d.tick     = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 24'h000001;
        end
        if (q.tick) begin
            d.phase = q.phase + 3'h1;
        end
        d.mode   = q.sw2[SW_MODE];
        d.up_div = gwa_up_div(q.sw2[SW_BAUD_LSB +: SW_BAUD_W]);
        // same decode in both modes; only the personality output differs
        d.hit  = up_poll_valid_i & map_hit;
        d.slot = map_slot;
        // upstream loss watchdog
        if (up_traffic_i) begin
            d.up_cnt  = '0;
            d.up_lost = 1'b0;
        end else if (q.tick && !q.up_lost) begin
            if (q.up_cnt == 8'(UP_LOSS_TICKS - 1)) begin
                d.up_lost = 1'b1;
            end else begin
                d.up_cnt = q.up_cnt + 8'h01;
            end
        end
        // field-bus receive and per-slot offline watchdog
        d.acc      = node_ok;
        d.acc_slot = 2'(fb_rx_node_i - 8'h01);
        for (int i = 0; i < SLOTS; i++) begin
            if (node_ok && d.acc_slot == 2'(i)) begin
                d.mon_cnt[i] = '0;
                d.online[i]  = 1'b1;
            end else if (q.tick && q.online[i]) begin
                if (q.mon_cnt[i] == 8'(MON_LOSS_TICKS - 1)) begin
                    d.online[i] = 1'b0;
                end else begin
                    d.mon_cnt[i] = q.mon_cnt[i] + 8'h01;
                end
            end
        end
        d.hw_prev = rom_fault_i;
        // alarm by severity
        if (rom_fault_i) begin
            d.alarm = ALM_HW;
        end else if (!q.cfg || q.slot_en == '0) begin
            d.alarm = ALM_UNCFG;
        end else if (q.up_lost) begin
            d.alarm = ALM_UP_LOST;
        end else if ((q.slot_en & ~q.online) != '0) begin
            d.alarm = ALM_OFFLINE;
        end else begin
            d.alarm = ALM_NONE;
        end
        unique case (q.alarm)
            ALM_NONE:    d.led_alarm = 1'b0;
            ALM_OFFLINE: d.led_alarm = 1'b1;
            ALM_UP_LOST: d.led_alarm = q.phase[2];
            ALM_UNCFG:   d.led_alarm = q.phase[1];
            ALM_HW:      d.led_alarm = q.phase[0];
        endcase
        d.led_stat = q.phase[2];
        d.led_up   = up_str;
        d.led_fb   = tx_str | br_str;
        d.led_br   = br_str;
        // sticky events; set wins, and only bits already reported are cleared
        irq_set              = '0;
        irq_set[IRQ_UP_LOST] = d.up_lost & ~q.up_lost;
        irq_set[IRQ_MON_OFF] = |(q.online & ~d.online & q.slot_en);
        irq_set[IRQ_FB_RX]   = node_ok;
        irq_set[IRQ_HW]      = rom_fault_i & ~q.hw_prev;
        // bus: first cycle latches, second cycle completes
        d.ack = req & ~q.ack;
        if (req && !q.ack) begin
            unique case (avs_address_i)
                REG_CTRL:     d.rdata = 32'({q.cfg, q.slot_en});
                REG_FB_BAUD:  d.rdata = 32'(q.fb_div);
                REG_STATUS:   d.rdata = status_word(q);
                REG_IRQ_STAT: d.rdata = 32'(q.irq_stat);
                REG_IRQ_MASK: d.rdata = 32'(q.irq_mask);
                default:      d.rdata = '0;
            endcase
        end
        if (req && q.ack && avs_read_i && avs_address_i == REG_IRQ_STAT) begin
            d.irq_stat = q.irq_stat & ~q.rdata[IRQ_W-1:0];
        end
        if (req && q.ack && avs_write_i) begin
            unique case (avs_address_i)
                REG_CTRL: begin
                    d.slot_en = avs_writedata_i[CTRL_EN_LSB +: SLOTS];
                    d.cfg     = avs_writedata_i[CTRL_CFG];
                end
                REG_FB_BAUD:  d.fb_div   = avs_writedata_i[15:0];
                REG_IRQ_MASK: d.irq_mask = avs_writedata_i[IRQ_W-1:0];
                default: ;
            endcase
        end
        d.irq_stat = d.irq_stat | irq_set;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign avs_waitrequest_o = req & ~q.ack;
    assign avs_readdata_o    = q.rdata;
    assign irq_o             = |(q.irq_stat & q.irq_mask);
    assign up_hit_o          = q.hit;
    assign up_slot_o         = q.slot;
    assign analog_mode_o     = q.mode;
    assign up_baud_div_o     = q.up_div;
    assign fb_rx_accept_o    = q.acc;
    assign fb_rx_slot_o      = q.acc_slot;
    assign fb_baud_div_o     = q.fb_div;
    assign led_status_o      = q.led_stat;
    assign led_alarm_o       = q.led_alarm;
    assign led_up_o          = q.led_up;
    assign led_fb_o          = q.led_fb;
    assign led_fb_bright_o   = q.led_br;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_mode;
        $stable(q.sw2) [*3] |-> analog_mode_o == q.sw2[SW_MODE];
    endproperty
    a_mode: assert property (p_mode) else $error("mode differs from switch 8");

    property p_hit_addr;
        up_hit_o |-> $past(up_poll_addr_i) == 5'($past(base)) + 5'(up_slot_o);
    endproperty
    a_hit_addr: assert property (p_hit_addr) else $error("hit at wrong board number");

    property p_hit_en;
        up_hit_o |-> (($past(q.slot_en) & (SLOTS'(1) << up_slot_o)) != '0) && (up_slot_o < 2'(SLOTS));
    endproperty
    a_hit_en: assert property (p_hit_en) else $error("disabled or absent slot answered");

    property p_miss;
        up_poll_valid_i && (up_poll_addr_i < 5'(base) || up_poll_addr_i > 5'(base) + 5'h02) |=> !up_hit_o;
    endproperty
    a_miss: assert property (p_miss) else $error("answer outside the three boards");

    property p_node;
        fb_rx_accept_o |-> $past(fb_rx_node_i) inside {8'h01, 8'h02, 8'h03}
            && 8'(fb_rx_slot_o) == $past(fb_rx_node_i) - 8'h01;
    endproperty
    a_node: assert property (p_node) else $error("bad node accepted");

    property p_bright;
        fb_rx_accept_o |=> led_fb_bright_o [*8];
    endproperty
    a_bright: assert property (p_bright) else $error("bright flash missing");

    property p_tx_blink;
        fb_tx_i |-> ##2 led_fb_o;
    endproperty
    a_tx_blink: assert property (p_tx_blink) else $error("transmit blink missing");

    property p_hw_first;
        rom_fault_i ##1 rom_fault_i |-> q.alarm == ALM_HW;
    endproperty
    a_hw_first: assert property (p_hw_first) else $error("hardware fault not on top");

    property p_green;
        $changed(led_status_o) |-> $past(q.tick, 2);
    endproperty
    a_green: assert property (p_green) else $error("status led off the time base");

    property p_steady;
        q.alarm == ALM_OFFLINE |=> led_alarm_o;
    endproperty
    a_steady: assert property (p_steady) else $error("offline alarm not steady");

    property p_up_baud;
        $stable(q.sw2) |=> up_baud_div_o == gwa_up_div($past(q.sw2[SW_BAUD_LSB +: SW_BAUD_W]));
    endproperty
    a_up_baud: assert property (p_up_baud) else $error("upstream divisor wrong");

endmodule // gwa_gateway

// >>> verilog/gwa_pkg.sv
// gwa_pkg: constants, register map and types of the gateway address and status block
package gwa_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int CLK_HZ          = 100_000_000;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TICK_PERIOD_MS  = 125;
    localparam int TICK_CYC        = (TICK_PERIOD_MS * 1_000_000) / CLK_PERIOD_NS;
    localparam int FLASH_MS        = 125;
    localparam int FLASH_TICKS     = FLASH_MS / TICK_PERIOD_MS;
    localparam int BRIGHT_MS       = 500;
    localparam int BRIGHT_TICKS    = BRIGHT_MS / TICK_PERIOD_MS;
    localparam int UP_LOSS_MS      = 10_000;
    localparam int UP_LOSS_TICKS   = UP_LOSS_MS / TICK_PERIOD_MS;
    localparam int MON_LOSS_MS     = 30_000;
    localparam int MON_LOSS_TICKS  = MON_LOSS_MS / TICK_PERIOD_MS;

    ////////////////////////////////////////////////////////////////////////////
    // slots and switches (switch n sits at bit n-1)
    localparam int SLOTS           = 3;
    localparam int MAX_BASE        = 14;
    localparam int SW_BASE_LSB     = 0;
    localparam int SW_BASE_W       = 4;
    localparam int SW_FB_RSVD      = 4;
    localparam int SW_BAUD_LSB     = 5;
    localparam int SW_BAUD_W       = 2;
    localparam int SW_MODE         = 7;

    ////////////////////////////////////////////////////////////////////////////
    // baud rates
    localparam int FB_BAUD_DEF     = 19200;
    localparam logic [15:0] FB_DIV_RST = 16'(CLK_HZ / FB_BAUD_DEF);
    localparam int UP_BAUD_0       = 9600;
    localparam int UP_BAUD_1       = 19200;
    localparam int UP_BAUD_2       = 38400;
    localparam int UP_BAUD_3       = 4800;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_FB_BAUD  = 5'h04;
    localparam logic [4:0] REG_STATUS   = 5'h08;
    localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
    localparam logic [4:0] REG_IRQ_MASK = 5'h10;
    localparam int CTRL_EN_LSB     = 0;
    localparam int CTRL_CFG        = 3;
    localparam int ST_BASE_LSB     = 0;
    localparam int ST_MODE         = 4;
    localparam int ST_BAUD_LSB     = 5;
    localparam int ST_BASE_BAD     = 7;
    localparam int ST_ONLINE_LSB   = 8;
    localparam int ST_UP_LOST      = 11;
    localparam int ST_HW           = 12;
    localparam int ST_SW5_ON       = 13;
    localparam int ST_ALARM_LSB    = 16;
    localparam int IRQ_W           = 4;
    localparam int IRQ_UP_LOST     = 0;
    localparam int IRQ_MON_OFF     = 1;
    localparam int IRQ_FB_RX       = 2;
    localparam int IRQ_HW          = 3;

    typedef enum logic [2:0] {ALM_NONE, ALM_OFFLINE, ALM_UP_LOST, ALM_UNCFG, ALM_HW} gwa_alarm_t;

    function automatic logic [15:0] gwa_up_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: gwa_up_div = 16'(CLK_HZ / UP_BAUD_0);
            2'h1: gwa_up_div = 16'(CLK_HZ / UP_BAUD_1);
            2'h2: gwa_up_div = 16'(CLK_HZ / UP_BAUD_2);
            2'h3: gwa_up_div = 16'(CLK_HZ / UP_BAUD_3);
        endcase
    endfunction

endpackage

// >>> verilog/gwa_slot_map.sv
// gwa_slot_map: maps an upstream board number onto one of the emulated slots
`timescale 1ns/1ps
module gwa_slot_map #(
    parameter int SLOTS = 3
) (
    // configuration
    input  wire logic [3:0]       base_i,
    input  wire logic [SLOTS-1:0] slot_en_i,
    // polled board number
    input  wire logic [4:0]       addr_i,
    // decode
    output logic                  hit_o,
    output logic [1:0]            slot_o
);
    logic [4:0] off;

    always_comb begin
        off    = addr_i - {1'b0, base_i};
        slot_o = off[1:0];
        hit_o  = 1'b0;
        if (addr_i >= {1'b0, base_i} && off < 5'(SLOTS)) begin
            hit_o = slot_en_i[off[1:0]];
        end
    end
endmodule // gwa_slot_map

// >>> verilog/gwa_stretch.sv
// gwa_stretch: holds a one-cycle trigger for a number of time-base ticks
`timescale 1ns/1ps
module gwa_stretch #(
    parameter int LEN = 1
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // time base and trigger
    input  wire logic tick_i,
    input  wire logic trig_i,
    // held output
    output logic      active_o
);
    typedef struct packed {
        logic [7:0] cnt;
    } gwa_str_t;

    gwa_str_t q, d;

    always_comb begin
        d = q;
        if (trig_i) begin
            d.cnt = 8'(LEN);
        end else if (tick_i && q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // first tick may come early, so a hold is LEN-1 to LEN ticks
    assign active_o = (q.cnt != 8'h00);
endmodule // gwa_stretch
